// *** inc/gpio_wake_map.svh ***
`ifndef GPIO_WAKE_MAP_SVH
`define GPIO_WAKE_MAP_SVH

// Register offsets in the runtime block
`define GLOBAL_EN_ADDR   8'h10
`define MISC_STS_ADDR    8'h11
`define EE_SEL_ADDR      8'h12
`define PME_STS_BASE     8'h20
`define GLOBAL_WAKE_ENABLE_BASE      8'h28
`define SMI_STS_BASE     8'h30
`define SMI_EN_BASE      8'h38
`define DATA_BASE        8'h48
`define LED_ONE_ADDR     8'h5D
`define LED_TWO_ADDR     8'h5E
`define DIR_BASE         8'h60
`define POL_BASE         8'h68
`define OTYPE_BASE       8'h70

// Field positions
`define LED_MODE_LSB     0
`define LED_FUNC_BIT     2
`define GLOBAL_EN_BIT    0

// Field encodings
`define LED_MODE_OFF     2'h0
`define LED_MODE_ON      2'h1
`define LED_MODE_BLINK   2'h2

// Reset values
`define DATA_RESET       48'h0000_0000_0000
`define DIR_RESET        48'hFFFF_FFF7_FFFF
`define POL_RESET        48'h0000_0000_0000
`define OTYPE_RESET      48'hFFFF_FFFF_FFFF
`define EE_SEL_RESET     6'h00
`define LED_RESET        8'h00

// Pin sets, one bit per pin slot ((tens group - 1) * 8 + units)
`define WAKE_MASK        48'h03FF_0AFF_F7FF
`define STANDBY_MASK     48'h03FF_0AF7_F700
`define PIN33_IDX        6'h13

// Timing
`define CLK_HZ           50000000
`define SLOW_HZ          32768
`define SLOW_TICK_CYCLES (`CLK_HZ / `SLOW_HZ)

`endif

// *** inc/gpio_wake_pkg.sv ***
`default_nettype none

package gpio_wake_pkg;

    typedef logic [47:0]      pin_vec_t;
    typedef logic [5:0][7:0]  grp_bytes_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        grp_bytes_t       data;
        grp_bytes_t       dir;
        grp_bytes_t       pol;
        grp_bytes_t       otype;
        pin_vec_t         pme_sts;
        pin_vec_t         global_wake_enable;
        pin_vec_t         smi_sts;
        pin_vec_t         smi_en;
        logic             global_en;
        logic [5:0]       misc;
        logic [5:0]       ee_sel;
        logic [1:0][7:0]  led;
        logic [10:0]      div;
        logic [15:0]      blink_cnt;
        logic             blink_on;
        pin_vec_t         pin_out;
        pin_vec_t         pin_oe;
        logic             wake;
        logic             mgmt;
        logic [7:0]       rdata;
        logic             rvalid;
    } wake_state_t;

endpackage

`default_nettype wire

// *** design/pin_edge_sync.sv ***
`default_nettype none

module pin_edge_sync #(
    parameter int W = 50
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Raw pins
    input  wire logic [W-1:0] raw,
    // Filtered level and edge pulses
    output logic      [W-1:0] level,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);

    initial begin
        if (W < 1) begin
            $error("pin_edge_sync: W must be at least 1");
        end
    end

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] level;
        logic [W-1:0] rise;
        logic [W-1:0] fall;
        logic [1:0]   arm;
    } sync_state_t;

    sync_state_t q;
    sync_state_t d;

    always_comb begin
        d       = q;
        d.s1    = raw;
        d.s2    = q.s1;
        d.s3    = q.s2;
        d.rise  = '0;
        d.fall  = '0;
        // Settle the first samples without reporting edges
        if (q.arm != 2'h3) begin
            d.arm   = q.arm + 2'h1;
            d.level = q.s2;
        end else begin
            for (int k = 0; k < W; k++) begin
                if (q.s2[k] == q.s3[k] && q.s3[k] != q.level[k]) begin
                    d.level[k] = q.s3[k];
                    d.rise[k]  = q.s3[k];
                    d.fall[k]  = ~q.s3[k];
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign level = q.level;
    assign rise  = q.rise;
    assign fall  = q.fall;

endmodule

`default_nettype wire

// *** design/gpio_wake_event_logic.sv ***
// Overview of operation
// - Every dedicated wake pin owns a status and enable bit, PME and SMI.
// - PME groups: 2=10-17, 3=20-22,24-27, 4=30-33,41,43,60,61, 5=50-57, 7=34-37.
// - SMI groups: 3 adds 60, 4 drops 60, 5, 7; pins 10-17 use enable group 6.
// - Pins 21,22,41,43,60,61 detect both edges when either-edge mode selected.
// - Either-edge pins own a misc status bit; that misc bit sets on both edges in every mode.
// - Pin 40 never takes part in wake detection.
// - Pin 43 comes up in plain general-purpose mode after reset.
// - Pin 33 resets as low output, reverts non-inverting when main power lost.
// - Standby-capable pins keep detecting and raising PME with main supply off.
// - Either-edge mode ignores direction, polarity and output type of the pin.
// - Polarity still inverts the data register view under either-edge mode.
// - Either-edge transitions request only with mode selected and enable set.
// - Either-edge status bits set on each transition, clear on write of one.
// - Misc status register gathers all six either-edge pins.
// - Status bits record events regardless of enables or either-edge selection.
// - Pins 60 and 61 have independent LED off, on, blink control registers.
// - Standby blinking uses the external slow clock; without it no blinking.
// - Outside either-edge mode polarity picks the setting edge; default rising.
// - PME request needs status, its enable and the global enable all set.
`include "gpio_wake_map.svh"

`default_nettype none

module gpio_wake_event_logic #(
    parameter int BLINK_HALF_TICKS = 16384
) (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst,
    // Runtime register port
    input  wire gpio_wake_pkg::reg_req_t reg_req,
    output logic [7:0]                   reg_rdata,
    output logic                         reg_rvalid,
    // General-purpose pins, slot = (tens group - 1) * 8 + units
    input  wire gpio_wake_pkg::pin_vec_t gpio_in,
    output gpio_wake_pkg::pin_vec_t      gpio_out,
    output gpio_wake_pkg::pin_vec_t      gpio_oe,
    // Power status and slow clock pins
    input  wire logic                    main_power_good,
    input  wire logic                    slow_clk_in,
    // Group requests to the power manager
    output logic                         wake_request_out,
    output logic                         mgmt_interrupt_out
);
    import gpio_wake_pkg::*;

    initial begin
        if (BLINK_HALF_TICKS < 1 || BLINK_HALF_TICKS > 65535) begin
            $error("gpio_wake_event_logic: BLINK_HALF_TICKS out of range");
        end
    end

    localparam logic [10:0] SLOW_DIV_LAST = 11'(`SLOW_TICK_CYCLES - 1);
    localparam logic [15:0] BLINK_LAST    = 16'(BLINK_HALF_TICKS - 1);
    localparam pin_vec_t    STANDBY_PINS  = `STANDBY_MASK;

    // Maps a status/enable register bit to its pin slot, MSB = valid
    function automatic logic [6:0] bit_map(input logic smi, input logic [2:0] grp, input logic [2:0] b);
        logic [6:0] m;
        m = 7'h00;
        case (grp)
            3'h2: begin
                if (!smi) begin
                    m = {1'b1, 3'h0, b};
                end
            end
            3'h3: begin
                if (b == 3'h3) begin
                    m = smi ? {1'b1, 6'h28} : 7'h00;
                end else begin
                    m = {1'b1, 3'h1, b};
                end
            end
            3'h4: begin
                case (b)
                    3'h4:    m = {1'b1, 6'h19};
                    3'h5:    m = {1'b1, 6'h1B};
                    3'h6:    m = smi ? {1'b1, 6'h29} : {1'b1, 6'h28};
                    3'h7:    m = smi ? 7'h00 : {1'b1, 6'h29};
                    default: m = {1'b1, 3'h2, b};
                endcase
            end
            3'h5: m = {1'b1, 3'h4, b};
            3'h6: begin
                if (smi) begin
                    m = {1'b1, 3'h0, b};
                end
            end
            3'h7: begin
                if (!b[2]) begin
                    m = {1'b1, 3'h2, 1'b1, b[1:0]};
                end
            end
            default: m = 7'h00;
        endcase
        return m;
    endfunction

    // Either-edge pins in ascending pin order
    function automatic logic [5:0] ee_idx(input int i);
        logic [5:0] r;
        case (i)
            0:       r = 6'h09;
            1:       r = 6'h0A;
            2:       r = 6'h19;
            3:       r = 6'h1B;
            4:       r = 6'h28;
            default: r = 6'h29;
        endcase
        return r;
    endfunction

    wake_state_t q;
    wake_state_t d;

    logic [49:0] sync_level;
    logic [49:0] sync_rise;
    logic [49:0] sync_fall;

    pin_edge_sync #(
        .W (50)
    ) u_sync (
        .clk   (clk),
        .rst   (rst),
        .raw   ({slow_clk_in, main_power_good, gpio_in}),
        .level (sync_level),
        .rise  (sync_rise),
        .fall  (sync_fall)
    );

    pin_vec_t    ee_vec;
    pin_vec_t    pol_eff;
    pin_vec_t    pin_evt;
    pin_vec_t    pme_clr;
    pin_vec_t    smi_clr;
    pin_vec_t    in_view;
    logic [5:0]  misc_set;
    logic [5:0]  misc_clr;
    logic        main_on;
    logic        tick;
    logic [6:0]  m;
    logic [2:0]  grp;
    logic [7:0]  rd_val;
    logic [7:0]  out_byte;
    logic        led_sel;
    logic [1:0]  led_mode;

    always_comb begin
        d        = q;
        ee_vec   = '0;
        pme_clr  = '0;
        smi_clr  = '0;
        misc_set = '0;
        misc_clr = '0;
        rd_val   = 8'h00;
        m        = 7'h00;
        out_byte = 8'h00;
        led_sel  = 1'b0;
        led_mode = `LED_MODE_OFF;
        grp      = reg_req.addr[2:0];
        main_on  = sync_level[48];

        for (int i = 0; i < 6; i++) begin
            ee_vec[ee_idx(i)] = q.ee_sel[i];
        end

        pol_eff = q.pol;
        // Losing main power forces the low-output pin back to plain polarity
        if (!main_on) begin
            pol_eff[`PIN33_IDX] = 1'b0;
        end

        // Edge selection per pin; masks drop pin 40 and main-only pins
        for (int k = 0; k < 48; k++) begin
            if (ee_vec[k]) begin
                pin_evt[k] = sync_rise[k] | sync_fall[k];
            end else begin
                pin_evt[k] = pol_eff[k] ? sync_fall[k] : sync_rise[k];
            end
        end
        pin_evt = pin_evt & `WAKE_MASK & (main_on ? {48{1'b1}} : `STANDBY_MASK);

        // Misc status catches both edges whatever the mode
        for (int i = 0; i < 6; i++) begin
            misc_set[i] = (sync_rise[ee_idx(i)] | sync_fall[ee_idx(i)])
                          & (main_on | STANDBY_PINS[ee_idx(i)]);
        end

        in_view = sync_level[47:0] ^ pol_eff;

        // Register writes
        if (reg_req.wr) begin
            case (reg_req.addr[7:3])
                `PME_STS_BASE >> 3, `SMI_STS_BASE >> 3: begin
                    for (int b = 0; b < 8; b++) begin
                        m = bit_map(reg_req.addr[4], grp, 3'(b));
                        if (m[6] && reg_req.wdata[b]) begin
                            if (reg_req.addr[4]) begin
                                smi_clr[m[5:0]] = 1'b1;
                            end else begin
                                pme_clr[m[5:0]] = 1'b1;
                            end
                        end
                    end
                end
                `GLOBAL_WAKE_ENABLE_BASE >> 3, `SMI_EN_BASE >> 3: begin
                    for (int b = 0; b < 8; b++) begin
                        m = bit_map(reg_req.addr[4], grp, 3'(b));
                        if (m[6]) begin
                            if (reg_req.addr[4]) begin
                                d.smi_en[m[5:0]] = reg_req.wdata[b];
                            end else begin
                                d.global_wake_enable[m[5:0]] = reg_req.wdata[b];
                            end
                        end
                    end
                end
                `DATA_BASE >> 3: begin
                    // Bits of input pins ignore the write
                    if (grp < 3'h6) begin
                        d.data[grp] = (q.data[grp] & q.dir[grp]) | (reg_req.wdata & ~q.dir[grp]);
                    end
                end
                `DIR_BASE >> 3: begin
                    if (grp < 3'h6) begin
                        d.dir[grp] = reg_req.wdata;
                    end
                end
                `POL_BASE >> 3: begin
                    if (grp < 3'h6) begin
                        d.pol[grp] = reg_req.wdata;
                    end
                end
                `OTYPE_BASE >> 3: begin
                    if (grp < 3'h6) begin
                        d.otype[grp] = reg_req.wdata;
                    end
                end
                default: begin
                    case (reg_req.addr)
                        `GLOBAL_EN_ADDR: d.global_en = reg_req.wdata[`GLOBAL_EN_BIT];
                        `MISC_STS_ADDR:  misc_clr    = reg_req.wdata[5:0];
                        `EE_SEL_ADDR:    d.ee_sel    = reg_req.wdata[5:0];
                        `LED_ONE_ADDR:   d.led[0]    = reg_req.wdata;
                        `LED_TWO_ADDR:   d.led[1]    = reg_req.wdata;
                        default: ;
                    endcase
                end
            endcase
        end

        // New events win over a same-cycle clear
        d.pme_sts = (q.pme_sts & ~pme_clr) | pin_evt;
        d.smi_sts = (q.smi_sts & ~smi_clr) | pin_evt;
        d.misc    = (q.misc & ~misc_clr) | misc_set;

        // Register reads, answered one cycle later
        if (reg_req.rd) begin
            case (reg_req.addr[7:3])
                `PME_STS_BASE >> 3, `GLOBAL_WAKE_ENABLE_BASE >> 3, `SMI_STS_BASE >> 3, `SMI_EN_BASE >> 3: begin
                    for (int b = 0; b < 8; b++) begin
                        m = bit_map(reg_req.addr[4], grp, 3'(b));
                        if (m[6]) begin
                            case (reg_req.addr[4:3])
                                2'h0:    rd_val[b] = q.pme_sts[m[5:0]];
                                2'h1:    rd_val[b] = q.global_wake_enable[m[5:0]];
                                2'h2:    rd_val[b] = q.smi_sts[m[5:0]];
                                default: rd_val[b] = q.smi_en[m[5:0]];
                            endcase
                        end
                    end
                end
                `DATA_BASE >> 3: begin
                    if (grp < 3'h6) begin
                        for (int b = 0; b < 8; b++) begin
                            if (q.dir[grp][b] || ee_vec[{grp, 3'(b)}]) begin
                                rd_val[b] = in_view[{grp, 3'(b)}];
                            end else begin
                                rd_val[b] = q.data[grp][b];
                            end
                        end
                    end
                end
                `DIR_BASE >> 3:   rd_val = (grp < 3'h6) ? q.dir[grp] : 8'h00;
                `POL_BASE >> 3:   rd_val = (grp < 3'h6) ? q.pol[grp] : 8'h00;
                `OTYPE_BASE >> 3: rd_val = (grp < 3'h6) ? q.otype[grp] : 8'h00;
                default: begin
                    case (reg_req.addr)
                        `GLOBAL_EN_ADDR: rd_val = {7'h00, q.global_en};
                        `MISC_STS_ADDR:  rd_val = {2'h0, q.misc};
                        `EE_SEL_ADDR:    rd_val = {2'h0, q.ee_sel};
                        `LED_ONE_ADDR:   rd_val = q.led[0];
                        `LED_TWO_ADDR:   rd_val = q.led[1];
                        default:         rd_val = 8'h00;
                    endcase
                end
            endcase
        end
        d.rdata  = rd_val;
        d.rvalid = reg_req.rd;

        // Slow tick: internal divider on main power, external clock on standby
        if (!main_on || q.div == SLOW_DIV_LAST) begin
            d.div = 11'h000;
        end else begin
            d.div = q.div + 11'h001;
        end
        tick = main_on ? (q.div == SLOW_DIV_LAST) : sync_rise[49];
        if (tick) begin
            if (q.blink_cnt == BLINK_LAST) begin
                d.blink_cnt = 16'h0000;
                d.blink_on  = ~q.blink_on;
            end else begin
                d.blink_cnt = q.blink_cnt + 16'h0001;
            end
        end

        // Pin drivers; output type bit set means open drain
        for (int k = 0; k < 48; k++) begin
            out_byte[0] = q.data[k / 8][k % 8] ^ pol_eff[k];
            led_sel     = 1'b0;
            if (k == 40 || k == 41) begin
                led_sel  = q.led[k - 40][`LED_FUNC_BIT];
                led_mode = q.led[k - 40][`LED_MODE_LSB +: 2];
            end
            if (led_sel) begin
                // LED lit means pin driven low, so open drain sinks current
                out_byte[0] = ~((led_mode == `LED_MODE_ON) ||
                                (led_mode == `LED_MODE_BLINK && q.blink_on));
            end
            d.pin_out[k] = out_byte[0];
            if (ee_vec[k]) begin
                d.pin_oe[k] = 1'b0;
            end else if (!led_sel && q.dir[k / 8][k % 8]) begin
                d.pin_oe[k] = 1'b0;
            end else if (!main_on && k == int'(`PIN33_IDX)) begin
                d.pin_oe[k] = 1'b1;
            end else begin
                d.pin_oe[k] = !q.otype[k / 8][k % 8] || !out_byte[0];
            end
        end

        // Group requests
        d.wake = q.global_en && |(q.pme_sts & q.global_wake_enable & `WAKE_MASK);
        d.mgmt = |(q.smi_sts & q.smi_en & `WAKE_MASK);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q           <= '0;
            q.data      <= `DATA_RESET;
            q.dir       <= `DIR_RESET;
            q.pol       <= `POL_RESET;
            q.otype     <= `OTYPE_RESET;
            q.ee_sel    <= `EE_SEL_RESET;
            q.led[0]    <= `LED_RESET;
            q.led[1]    <= `LED_RESET;
        end else begin
            q <= d;
        end
    end

    assign reg_rdata          = q.rdata;
    assign reg_rvalid         = q.rvalid;
    assign gpio_out           = q.pin_out;
    assign gpio_oe            = q.pin_oe;
    assign wake_request_out   = q.wake;
    assign mgmt_interrupt_out = q.mgmt;

endmodule

`default_nettype wire

// *** sim/gpio_wake_assertions.sv ***
`default_nettype none

module gpio_wake_checker (
    // Clock and reset
    input wire logic                    clk,
    input wire logic                    rst,
    // Register port
    input wire gpio_wake_pkg::reg_req_t reg_req,
    input wire logic [7:0]              reg_rdata,
    input wire logic                    reg_rvalid,
    // Pins and supply
    input wire gpio_wake_pkg::pin_vec_t gpio_in,
    input wire gpio_wake_pkg::pin_vec_t gpio_out,
    input wire gpio_wake_pkg::pin_vec_t gpio_oe,
    input wire logic                    main_power_good,
    input wire logic                    slow_clk_in,
    // Requests
    input wire logic                    wake_request_out,
    input wire logic                    mgmt_interrupt_out
);
    import gpio_wake_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // No write, no pin or supply change
    sequence quiet_s;
        !reg_req.wr && $stable(gpio_in) && $stable(main_power_good);
    endsequence
    // Standby with the slow clock stopped
    sequence standby_still_s;
        !main_power_good && $stable(slow_clk_in) && !reg_req.wr;
    endsequence
    sequence led_on_wr_s;
        reg_req.wr && reg_req.addr == 8'h5D && reg_req.wdata[2:0] == 3'h5;
    endsequence

    read_answer_a: assert property (reg_req.rd |=> reg_rvalid)
        else $error("read not answered");
    read_cause_a: assert property (reg_rvalid |-> $past(reg_req.rd))
        else $error("read valid without read");
    rdata_idle_a: assert property (!reg_rvalid |-> reg_rdata == 8'h00)
        else $error("read data not idle");
    pin33_reset_a: assert property ($past(rst) |=> gpio_oe[19] && !gpio_out[19])
        else $error("pin 33 not low output after reset");
    pin33_standby_a: assert property (!main_power_good [*6] |-> gpio_oe[19])
        else $error("pin 33 not output on standby");
    wake_hold_a: assert property (quiet_s [*8] |-> $stable(wake_request_out))
        else $error("wake request moved without cause");
    mgmt_hold_a: assert property (quiet_s [*8] |-> $stable(mgmt_interrupt_out))
        else $error("mgmt request moved without cause");
    blink_still_a: assert property (standby_still_s [*8] |-> $stable(gpio_out[41:40]) && $stable(gpio_oe[41:40]))
        else $error("LED moved without slow clock");
    led_lit_a: assert property (led_on_wr_s |-> ##[1:3] (gpio_oe[40] && !gpio_out[40]))
        else $error("LED not lit after on");
endmodule

bind gpio_wake_event_logic gpio_wake_checker gpio_wake_checker_inst (
    .clk(clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .main_power_good(main_power_good),
    .slow_clk_in(slow_clk_in), .wake_request_out(wake_request_out), .mgmt_interrupt_out(mgmt_interrupt_out)
);

`default_nettype wire

// *** sim/chipset_model.sv ***
`default_nettype none

module chipset_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Requests from the device
    input wire logic wake_request_out,
    input wire logic mgmt_interrupt_out,
    // Assertions seen
    output var int   wake_seen,
    output var int   mgmt_seen
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wake_q;
    logic mgmt_q;

    // Level requests: one count per assertion, not per cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wake_q <= 1'b0;
            mgmt_q <= 1'b0;
            wake_seen <= 0;
            mgmt_seen <= 0;
        end else begin
            wake_q <= wake_request_out;
            mgmt_q <= mgmt_interrupt_out;
            wake_seen <= wake_seen + int'(wake_request_out && !wake_q);
            mgmt_seen <= mgmt_seen + int'(mgmt_interrupt_out && !mgmt_q);
        end
    end
endmodule

`default_nettype wire

// *** sim/tb.sv ***
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import gpio_wake_pkg::*;

    logic       clk;
    logic       rst;
    reg_req_t   req;
    logic [7:0] rdata;
    logic       rvalid;
    pin_vec_t   pin_in;
    pin_vec_t   pin_wire;
    pin_vec_t   pin_out;
    pin_vec_t   pin_oe;
    logic       power_good;
    logic       slow_clk;
    logic       wake;
    logic       mgmt;
    int         wake_seen;
    int         mgmt_seen;
    int         errors;
    int         comparisons;
    logic [7:0] d;

    // Driven pins read back their own level
    assign pin_wire = (pin_oe & pin_out) | (~pin_oe & pin_in);

    gpio_wake_event_logic #(.BLINK_HALF_TICKS(2)) gpio_wake_event_logic_inst (
        .clk(clk), .rst(rst), .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid),
        .gpio_in(pin_wire), .gpio_out(pin_out), .gpio_oe(pin_oe), .main_power_good(power_good),
        .slow_clk_in(slow_clk), .wake_request_out(wake), .mgmt_interrupt_out(mgmt)
    );
    chipset_model chipset_model_inst (
        .clk(clk), .rst(rst), .wake_request_out(wake), .mgmt_interrupt_out(mgmt),
        .wake_seen(wake_seen), .mgmt_seen(mgmt_seen)
    );

    always #10 clk = ~clk;

    task automatic check(string name, logic [47:0] seen, logic [47:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(logic [7:0] a, logic [7:0] v);
        @(negedge clk);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = v;
        @(negedge clk);
        req.wr = 1'b0;
        @(negedge clk);
    endtask

    task automatic rd(logic [7:0] a);
        @(negedge clk);
        req.rd = 1'b1;
        req.addr = a;
        @(negedge clk);
        req.rd = 1'b0;
        check("rvalid", rvalid, 1'b1);
        d = rdata;
        @(negedge clk);
    endtask

    // Pin edge, then the fixed six-edge latency to the request outputs plus margin
    task automatic pin(int s, logic v);
        @(negedge clk);
        pin_in[s] = v;
        repeat (8) @(negedge clk);
    endtask

    task automatic reset_values();
        check("oe", pin_oe, 48'h0000_0008_0000);
        check("pin33", pin_out[19], 1'b0);
        rd(8'h62);
        check("dir3", d, 8'hF7);
        rd(8'h5E);
        check("led_two_control", d, 8'h00);
        wr(8'h80, 8'hFF);
        rd(8'h80);
        check("unmapped", d, 8'h00);
    endtask

    task automatic pme_path();
        wr(8'h2A, 8'h01);
        pin(0, 1'b1);
        check("no global", wake, 1'b0);
        rd(8'h22);
        check("pme g2", d, 8'h01);
        rd(8'h36);
        check("smi g6", d, 8'h01);
        wr(8'h10, 8'h01);
        check("wake", wake, 1'b1);
        @(negedge clk);
        check("seen", wake_seen, 1);
        wr(8'h22, 8'h01);
        pin(0, 1'b0);
        check("fall", wake, 1'b0);
        wr(8'h68, 8'h01);
        repeat (8) @(negedge clk);
        wr(8'h22, 8'h01);
        pin(0, 1'b1);
        check("inv rise", wake, 1'b0);
        pin(0, 1'b0);
        check("inv fall", wake, 1'b1);
        wr(8'h68, 8'h00);
        repeat (8) @(negedge clk);
        wr(8'h22, 8'h01);
    endtask

    task automatic either_edge();
        pin(9, 1'b1);
        pin(9, 1'b0);
        rd(8'h11);
        check("misc", d, 8'h01);
        rd(8'h23);
        check("pme g3", d, 8'h02);
        check("not enabled", wake, 1'b0);
        wr(8'h11, 8'h01);
        wr(8'h23, 8'h02);
        wr(8'h33, 8'h02);
        rd(8'h23);
        check("cleared", d, 8'h00);
        wr(8'h12, 8'h03);
        wr(8'h2B, 8'h02);
        wr(8'h3B, 8'h02);
        pin(9, 1'b1);
        check("wake rise", wake, 1'b1);
        check("mgmt rise", mgmt, 1'b1);
        wr(8'h23, 8'h02);
        wr(8'h33, 8'h02);
        check("clear", {wake, mgmt}, 2'b00);
        pin(9, 1'b0);
        check("fall", {wake, mgmt}, 2'b11);
        check("mgmt seen", mgmt_seen, 2);
        wr(8'h69, 8'h04);
        wr(8'h61, 8'hFB);
        wr(8'h71, 8'hFB);
        check("ee oe", pin_oe[10], 1'b0);
        rd(8'h49);
        check("ee data", d[2], 1'b1);
        pin(10, 1'b1);
        rd(8'h11);
        check("misc order", d, 8'h03);
        wr(8'h11, 8'hFF);
        wr(8'h23, 8'hFF);
        wr(8'h33, 8'hFF);
    endtask

    task automatic pin_forty();
        wr(8'h2C, 8'hFF);
        pin(24, 1'b1);
        check("pin40", wake, 1'b0);
        wr(8'h2C, 8'h00);
    endtask

    task automatic led_standby();
        logic lit;
        int   toggles;
        wr(8'h5D, 8'h05);
        check("led on", {pin_oe[40], pin_out[40]}, 2'b10);
        rd(8'h5D);
        check("led rw", d, 8'h05);
        wr(8'h5E, 8'h06);
        power_good = 1'b0;
        repeat (8) @(negedge clk);
        pin(32, 1'b1);
        rd(8'h25);
        check("standby g5", d, 8'h01);
        pin(1, 1'b1);
        rd(8'h22);
        check("standby g2", d, 8'h00);
        lit = pin_oe[41] & ~pin_out[41];
        toggles = 0;
        for (int i = 0; i < 16; i++) begin
            repeat (4) @(negedge clk);
            slow_clk = ~slow_clk;
            toggles += int'(lit != (pin_oe[41] & ~pin_out[41]));
            lit = pin_oe[41] & ~pin_out[41];
        end
        check("blink", toggles > 1, 1'b1);
        repeat (8) @(negedge clk);
        lit = pin_oe[41] & ~pin_out[41];
        repeat (12) @(negedge clk);
        check("no clock", pin_oe[41] & ~pin_out[41], lit);
        power_good = 1'b1;
    endtask

    task automatic complete_run();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        complete_run();
    end

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        req = '0;
        pin_in = '0;
        power_good = 1'b1;
        slow_clk = 1'b0;
        errors = 0;
        comparisons = 0;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        repeat (8) @(negedge clk);
        reset_values();
        pme_path();
        either_edge();
        pin_forty();
        led_standby();
        complete_run();
    end
endmodule

`default_nettype wire
